// file: dv/fuse_bit_command_guard_tb.sv
// testbench for the fuse bit command guard: wishbone register tasks and command sequences
// assumes the design from shared/fuse_guard_pkg.sv, one 125 MHz clock, synchronous reset
`timescale 1ns/1ns
module fuse_bit_command_guard_tb;
  // ****************************************
  // signals
  // ****************************************
  logic                    clk_i          = 1'b0;
  logic                    rst_i          = 1'b1;
  fuse_guard_pkg::wb_req_t wb_i           = '0;
  fuse_guard_pkg::wb_rsp_t wb_o;
  logic                    security_bit_i = 1'b0;
  logic [15:0]             page_query_i   = 16'h0000;
  logic                    page_denied_o;
  logic                    ext_fetch_block_fuse_o;
  logic [2:0]              boot_area_size_fuses_o;
  logic                    secure_state_enable_o;
  logic                    secure_debug_enable_o;
  logic                    user_prot_fuse_o;
  logic                    irq_o;
  logic [31:0]             rd;
  int                      n_errors       = 0;
  int                      num_checks     = 0;
  int                      n_irq          = 0;

  always #4 clk_i = ~clk_i;

  // irq is a single-cycle pulse, so count it at every rising edge
  always @(posedge clk_i)
    if (irq_o === 1'b1)
      n_irq <= n_irq + 1;

  fuse_bit_command_guard dut (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_i                   (wb_i),
    .wb_o                   (wb_o),
    .security_bit_i         (security_bit_i),
    .page_query_i           (page_query_i),
    .page_denied_o          (page_denied_o),
    .ext_fetch_block_fuse_o (ext_fetch_block_fuse_o),
    .boot_area_size_fuses_o (boot_area_size_fuses_o),
    .secure_state_enable_o  (secure_state_enable_o),
    .secure_debug_enable_o  (secure_debug_enable_o),
    .user_prot_fuse_o       (user_prot_fuse_o),
    .irq_o                  (irq_o)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_o.ack !== 1'b1 && n < 20);
    rd = wb_o.dat;
    wb_i <= '0;
    if (wb_o.ack !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
  endtask

  // status read right after the write carries the error flags, so it is checked there
  task automatic run(input logic [7:0] key, input logic [15:0] page, input logic [5:0] code,
                     input logic busy, input logic lerr, input logic perr);
    int n;
    wb(1'b1, fuse_guard_pkg::ADDR_CMD, {key, page, 2'b00, code});
    wb(1'b0, fuse_guard_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status", {60'h0, rd[3:0] & 4'hd}, {60'h0, perr, lerr, 1'b0, ~busy});
    n = 0;
    while (rd[0] !== 1'b1 && n < 200)
    begin
      wb(1'b0, fuse_guard_pkg::ADDR_STATUS, 32'h0000_0000);
      n++;
    end
    if (rd[0] !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic fuses(input logic [63:0] exp);
    logic [31:0] hi;
    wb(1'b0, fuse_guard_pkg::ADDR_FUSE_HI, 32'h0000_0000);
    hi = rd;
    wb(1'b0, fuse_guard_pkg::ADDR_FUSE_LO, 32'h0000_0000);
    chk("fuses", {hi, rd}, exp);
  endtask

  task automatic outs(input logic [6:0] exp);
    chk("outputs", {57'h0, ext_fetch_block_fuse_o, boot_area_size_fuses_o, secure_state_enable_o,
        secure_debug_enable_o, user_prot_fuse_o}, {57'h0, exp});
  endtask

  task automatic query(input logic [15:0] page, input logic exp);
    @(posedge clk_i);
    page_query_i <= page;
    repeat (2) @(posedge clk_i);
    #1;
    chk("page_denied", {63'h0, page_denied_o}, {63'h0, exp});
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  logic [5:0]  lk_code [5] = '{6'h08, 6'h08, 6'h08, 6'h0a, 6'h0b};
  logic [15:0] lk_page [5] = '{16'd17, 16'd16, 16'd22, {5'h0, 8'hff, 3'd2}, 16'd0};

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    outs(7'h79);
    fuses(64'hffff_ffff_ffff_ffff);
    wb(1'b0, 5'h14, 32'hffff_ffff);
    chk("unmapped", {32'h0, rd}, 64'h0);
    wb(1'b1, fuse_guard_pkg::ADDR_CTRL, 32'h0000_0001);
    run(8'ha5, 16'd16, fuse_guard_pkg::CMD_BIT_PROG, 1'b1, 1'b0, 1'b0);
    outs(7'h39);
    fuses(64'hffff_ffff_fffe_ffff);
    chk("irq", 64'(n_irq), 64'd1);
    run(8'ha5, 16'd16, fuse_guard_pkg::CMD_BIT_CLEAR, 1'b1, 1'b0, 1'b0);
    run(8'h5a, 16'd5, fuse_guard_pkg::CMD_BIT_PROG, 1'b0, 1'b0, 1'b1);
    run(8'ha5, 16'd5, 6'h3f, 1'b0, 1'b0, 1'b1);
    wb(1'b0, fuse_guard_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("cleared", {62'h0, rd[3:2]}, 64'h0);
    fuses(64'hffff_ffff_ffff_ffff);
    chk("irq", 64'(n_irq), 64'd2);
    // byte 2 = d7: boot 3, secure 01
    run(8'ha5, {5'h0, 8'hd7, 3'd2}, fuse_guard_pkg::CMD_BYTE_PROG, 1'b1, 1'b0, 1'b0);
    outs(7'h5f);
    query(16'd15, 1'b1);
    query(16'd16, 1'b0);
    run(8'ha5, 16'd20, fuse_guard_pkg::CMD_BIT_CLEAR, 1'b1, 1'b1, 1'b0);
    fuses(64'hffff_ffff_ffd7_ffff);
    do_reset();
    outs(7'h79);
    // byte 2 = a0: fetch blocked, boot 0, secure 10, user protection on
    run(8'ha5, {5'h0, 8'ha0, 3'd2}, fuse_guard_pkg::CMD_BYTE_PROG, 1'b1, 1'b0, 1'b0);
    outs(7'h04);
    query(16'd127, 1'b1);
    query(16'd128, 1'b0);
    query(16'h0000, 1'b1);
    @(posedge clk_i);
    security_bit_i <= 1'b1;
    wb(1'b0, fuse_guard_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("security", {63'h0, rd[4]}, 64'h1);
    for (int i = 0; i < 5; i++)
      run(8'ha5, lk_page[i], lk_code[i], 1'b1, 1'b1, 1'b0);
    fuses(64'hffff_ffff_ffa0_ffff);
    @(posedge clk_i);
    security_bit_i <= 1'b0;
    do_reset();
    run(8'ha5, 16'h0035, fuse_guard_pkg::CMD_LOCK_REGION, 1'b1, 1'b0, 1'b0);
    fuses(64'hffff_ffff_ffff_fff7);
    query(16'h003a, 1'b1);
    query(16'h0045, 1'b0);
    // second command while the unlock is still running must be refused with a program error
    wb(1'b1, fuse_guard_pkg::ADDR_CMD, {8'ha5, 16'h0035, 2'b00, fuse_guard_pkg::CMD_UNLOCK_REGION});
    run(8'ha5, 16'd9, fuse_guard_pkg::CMD_BIT_PROG, 1'b1, 1'b0, 1'b1);
    fuses(64'hffff_ffff_ffff_ffff);
    run(8'ha5, 16'd40, fuse_guard_pkg::CMD_BIT_PROG, 1'b1, 1'b0, 1'b0);
    fuses(64'hffff_feff_ffff_ffff);
    run(8'ha5, 16'd0, fuse_guard_pkg::CMD_ALL_CLEAR, 1'b1, 1'b0, 1'b0);
    fuses(64'hffff_ffff_ffff_ffff);
    give_verdict();
  end
endmodule // fuse_bit_command_guard_tb

// file: shared/fuse_guard_pkg.sv
// constants, bus carriers and state layout for the fuse bit command guard
// assumes a classic wishbone master on the same 125 MHz clock as the block
package fuse_guard_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS  = 1000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_CMD     = 5'h04;
  localparam logic [4:0] ADDR_STATUS  = 5'h08;
  localparam logic [4:0] ADDR_FUSE_HI = 5'h0c;
  localparam logic [4:0] ADDR_FUSE_LO = 5'h10;
  localparam int KEY_LSB      = 24;
  localparam int PAGE_LSB     = 8;
  localparam int CTRL_RDY_IE  = 0;
  localparam int ST_READY     = 0;
  localparam int ST_LOCK_ERR  = 2;
  localparam int ST_PROG_ERR  = 3;
  localparam int ST_SECURITY  = 4;
  localparam logic [7:0] CMD_KEY = 8'ha5;

  // ****************************************
  // commands
  // ****************************************
  localparam logic [5:0] CMD_NOP           = 6'h00;
  localparam logic [5:0] CMD_LOCK_REGION   = 6'h02;
  localparam logic [5:0] CMD_UNLOCK_REGION = 6'h03;
  localparam logic [5:0] CMD_BIT_PROG      = 6'h07;
  localparam logic [5:0] CMD_BIT_CLEAR     = 6'h08;
  localparam logic [5:0] CMD_BYTE_PROG     = 6'h0a;
  localparam logic [5:0] CMD_ALL_CLEAR     = 6'h0b;

  // ****************************************
  // fuse layout
  // ****************************************
  localparam int EXT_FETCH_BIT = 16;
  localparam int BOOT_LSB      = 17;
  localparam int SEC_LSB       = 20;
  localparam int USER_PROT_BIT = 22;
  localparam int REGION_LSB    = 4;
  localparam logic [63:0] FUSE_RESET     = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] SEC_LOCKED_MSK = 64'h0000_0000_004f_0000;
  localparam logic [63:0] SECURE_MSK     = 64'h0000_0000_0030_0000;
  localparam logic [8:0]  PAGES_ALL      = 9'h100;
  localparam logic [7:0]  PROG_CNT       = 8'(PROG_CYCLES);

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    wb_rsp_t     rsp;
    logic [63:0] fuses;
    logic [63:0] pend;
    logic        busy;
    logic [7:0]  cnt;
    logic        sec_at_cmd;
    logic        ready;
    logic        lock_err;
    logic        prog_err;
    logic        rdy_ie;
    logic [15:0] page;
    logic [5:0]  code;
    logic        irq;
    logic        denied;
    logic        sec_en;
    logic        sec_dbg_en;
  } state_t;

endpackage

// file: verilog/fuse_bit_command_guard.sv
// fuse bit command guard: fuse commands, protection checks and fuse decode
// assumes security_bit_i and page_query_i are synchronous to clk_i
//
// Overview of operation
// [R1] fuses 15:0 are the sixteen region lock bits
// [R2] fuse 16 is routed out as the external fetch block, zero forbids
// [R3] with security set no command may alter the fetch block fuse
// [R4] boot fuses 19:17 decode to protected pages, 7 none through 0 pages 0-127
// [R5] pages inside the boot range are reported as denied for erase or program
// [R6] boot fuses change only while the security bit is clear
// [R7] secure fuses 21:20 decode to secure enable and secure debug enable
// [R8] fuse 22 zero enables user protection; changes only with security clear
// [R9] bit program and bit clear touch only the fuse named by the page field
// [R10] byte program: index in page bits 2:0, value in bits 10:3
// [R11] byte program to byte 2 with security set is refused with lock error
// [R12] erase of all fuses is refused with lock error when security is set
// [R13] wrong key or invalid command code sets the program error flag
// [R14] boot, fetch block or user protection change under security gives lock error
// [R15] secure fuse change while secure mode is on gives lock error
// [R16] region lock and unlock commands modify the lowest sixteen fuses
// [R17] fuse values are readable at dedicated bus addresses
// [R18] a lock fuse at one is unlocked, at zero locked
// [R19] a command acts only when the key byte holds a5
// [R20] reading the status register clears both error flags
// [R21] ready drops on command write, rises on completion, optional interrupt
// [R22] all checks precede any fuse change; a refused command changes nothing
// [R23] decoded outputs follow current fuses, also right after reset
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module fuse_bit_command_guard (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire fuse_guard_pkg::wb_req_t wb_i,
  output      fuse_guard_pkg::wb_rsp_t wb_o,
  input  wire logic                    security_bit_i,
  input  wire logic [15:0]             page_query_i,
  output      logic                    page_denied_o,
  output      logic                    ext_fetch_block_fuse_o,
  output      logic [2:0]              boot_area_size_fuses_o,
  output      logic                    secure_state_enable_o,
  output      logic                    secure_debug_enable_o,
  output      logic                    user_prot_fuse_o,
  output      logic                    irq_o
);

  localparam int DONE_LAT = fuse_guard_pkg::PROG_CYCLES;

  fuse_guard_pkg::state_t s_reg;
  fuse_guard_pkg::state_t s_next;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] boot_limit(input logic [2:0] bp);
    if (bp == 3'h7)
      return 9'h000;
    return 9'(fuse_guard_pkg::PAGES_ALL >> (4'(bp) + 4'h1));
  endfunction

  logic        req;
  logic        cmd_wr;
  logic [7:0]  key;
  logic [15:0] pg;
  logic [5:0]  code;
  logic        valid;
  logic [63:0] mask;
  logic [63:0] newf;
  logic        lock_fail;

  assign req    = wb_i.cyc & wb_i.stb & ~s_reg.rsp.ack;
  assign cmd_wr = req & wb_i.we & (wb_i.adr == fuse_guard_pkg::ADDR_CMD) & (&wb_i.sel);
  assign key    = wb_i.dat[31:fuse_guard_pkg::KEY_LSB];
  assign pg     = wb_i.dat[23:fuse_guard_pkg::PAGE_LSB];
  assign code   = wb_i.dat[5:0];

  // ****************************************
  // command decode and protection checks
  // ****************************************
  always_comb
  begin
    valid = 1'b1;
    mask  = 64'h0000_0000_0000_0000;
    newf  = s_reg.fuses;
    unique case (code)
      fuse_guard_pkg::CMD_NOP:
      begin
        valid = 1'b1;
      end
      fuse_guard_pkg::CMD_LOCK_REGION, fuse_guard_pkg::CMD_UNLOCK_REGION:
      begin
        mask = 64'(1) << pg[fuse_guard_pkg::REGION_LSB +: 4]; // R16 R1
        newf = (code == fuse_guard_pkg::CMD_LOCK_REGION) ? (s_reg.fuses & ~mask) : (s_reg.fuses | mask); // R18
      end
      fuse_guard_pkg::CMD_BIT_PROG, fuse_guard_pkg::CMD_BIT_CLEAR:
      begin
        valid = (pg[15:6] == 10'h000);
        mask  = 64'(1) << pg[5:0]; // R9
        newf  = (code == fuse_guard_pkg::CMD_BIT_PROG) ? (s_reg.fuses & ~mask) : (s_reg.fuses | mask);
      end
      fuse_guard_pkg::CMD_BYTE_PROG:
      begin
        mask = 64'h0000_0000_0000_00ff << {pg[2:0], 3'h0}; // R10
        newf = (s_reg.fuses & ~mask) | ((64'(pg[10:3]) << {pg[2:0], 3'h0}) & mask);
      end
      fuse_guard_pkg::CMD_ALL_CLEAR:
      begin
        mask = fuse_guard_pkg::FUSE_RESET; // R12
        newf = fuse_guard_pkg::FUSE_RESET;
      end
      default:
      begin
        valid = 1'b0; // R13
      end
    endcase
    // byte 2 and the erase of all fuses both cover the secured bits
    lock_fail = (security_bit_i & |(mask & fuse_guard_pkg::SEC_LOCKED_MSK)) // R3 R6 R8 R11 R12 R14
              | (s_reg.sec_en & |(mask & fuse_guard_pkg::SECURE_MSK)); // R15
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_next         = s_reg;
    s_next.irq     = 1'b0;
    s_next.rsp.ack = req;
    s_next.rsp.dat = 32'h0000_0000;
    if (s_reg.busy)
    begin
      if (s_reg.cnt == 8'h01)
      begin
        s_next.fuses = s_reg.pend; // R22
        s_next.busy  = 1'b0;
        s_next.ready = 1'b1; // R21
        s_next.irq   = s_reg.rdy_ie; // R21
      end
      else
        s_next.cnt = s_reg.cnt - 8'h01;
    end
    if (req & ~wb_i.we)
    begin
      unique case (wb_i.adr)
        fuse_guard_pkg::ADDR_CTRL:
          s_next.rsp.dat[fuse_guard_pkg::CTRL_RDY_IE] = s_reg.rdy_ie;
        fuse_guard_pkg::ADDR_CMD:
          s_next.rsp.dat = {8'h00, s_reg.page, 2'h0, s_reg.code};
        fuse_guard_pkg::ADDR_STATUS:
        begin
          s_next.rsp.dat[fuse_guard_pkg::ST_READY]    = s_reg.ready;
          s_next.rsp.dat[fuse_guard_pkg::ST_LOCK_ERR] = s_reg.lock_err;
          s_next.rsp.dat[fuse_guard_pkg::ST_PROG_ERR] = s_reg.prog_err;
          s_next.rsp.dat[fuse_guard_pkg::ST_SECURITY] = security_bit_i;
          s_next.lock_err = 1'b0; // R20
          s_next.prog_err = 1'b0; // R20
        end
        fuse_guard_pkg::ADDR_FUSE_HI:
          s_next.rsp.dat = s_reg.fuses[63:32]; // R17
        fuse_guard_pkg::ADDR_FUSE_LO:
          s_next.rsp.dat = s_reg.fuses[31:0]; // R17
        default:
          s_next.rsp.dat = 32'h0000_0000;
      endcase
    end
    if (req & wb_i.we & (wb_i.adr == fuse_guard_pkg::ADDR_CTRL) & wb_i.sel[0])
      s_next.rdy_ie = wb_i.dat[fuse_guard_pkg::CTRL_RDY_IE];
    if (cmd_wr)
    begin
      // a command during a busy period is dropped so the pending fuse image stays intact
      if ((key != fuse_guard_pkg::CMD_KEY) | s_reg.busy | ~valid)
        s_next.prog_err = 1'b1; // R13 R19
      else
      begin
        s_next.page       = pg;
        s_next.code       = code;
        s_next.ready      = 1'b0; // R21
        s_next.busy       = 1'b1;
        s_next.cnt        = fuse_guard_pkg::PROG_CNT;
        s_next.sec_at_cmd = security_bit_i;
        s_next.pend       = lock_fail ? s_reg.fuses : newf; // R22
        if (lock_fail)
          s_next.lock_err = 1'b1; // R14 R15
      end
    end
    s_next.sec_en     = s_next.fuses[21] ^ s_next.fuses[fuse_guard_pkg::SEC_LSB]; // R7 R23
    s_next.sec_dbg_en = ~s_next.fuses[21] & s_next.fuses[fuse_guard_pkg::SEC_LSB]; // R7 R23
    s_next.denied = ({7'h00, boot_limit(s_reg.fuses[19:fuse_guard_pkg::BOOT_LSB])} > page_query_i) // R4 R5
                  | ~s_reg.fuses[page_query_i[fuse_guard_pkg::REGION_LSB +: 4]]; // R18
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg       <= '0;
      s_reg.fuses <= fuse_guard_pkg::FUSE_RESET;
      s_reg.pend  <= fuse_guard_pkg::FUSE_RESET;
      s_reg.ready <= 1'b1;
      s_reg.sec_en     <= fuse_guard_pkg::FUSE_RESET[21] ^ fuse_guard_pkg::FUSE_RESET[20]; // R23
      s_reg.sec_dbg_en <= ~fuse_guard_pkg::FUSE_RESET[21] & fuse_guard_pkg::FUSE_RESET[20]; // R23
    end
    else
      s_reg <= s_next;
  end

  assign wb_o                   = s_reg.rsp;
  assign page_denied_o          = s_reg.denied;
  assign ext_fetch_block_fuse_o = s_reg.fuses[fuse_guard_pkg::EXT_FETCH_BIT]; // R2 R23
  assign boot_area_size_fuses_o = s_reg.fuses[19:fuse_guard_pkg::BOOT_LSB]; // R4
  assign secure_state_enable_o  = s_reg.sec_en;
  assign secure_debug_enable_o  = s_reg.sec_dbg_en;
  assign user_prot_fuse_o       = s_reg.fuses[fuse_guard_pkg::USER_PROT_BIT]; // R8
  assign irq_o                  = s_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  a_bad_key_flags: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    cmd_wr && key != fuse_guard_pkg::CMD_KEY |=> s_reg.prog_err && $stable(s_reg.code))
    else $error("bad key did not flag program error");

  a_ready_drops: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    cmd_wr && key == fuse_guard_pkg::CMD_KEY && !s_reg.busy && valid |=> !s_reg.ready)
    else $error("ready did not drop on command");

  a_ready_returns: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    $fell(s_reg.ready) |-> ##[DONE_LAT:DONE_LAT] s_reg.ready)
    else $error("ready did not return in time");

  a_fuses_hold_busy: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    s_reg.busy && s_reg.cnt != 8'h01 |=> $stable(s_reg.fuses))
    else $error("fuses changed before completion");

  a_secured_fuses_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    s_reg.busy && s_reg.cnt == 8'h01 && s_reg.sec_at_cmd
    |=> (s_reg.fuses & fuse_guard_pkg::SEC_LOCKED_MSK) == ($past(s_reg.fuses) & fuse_guard_pkg::SEC_LOCKED_MSK))
    else $error("secured fuse changed under security");

  a_erase_all_refused: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    cmd_wr && key == fuse_guard_pkg::CMD_KEY && !s_reg.busy && security_bit_i
      && code == fuse_guard_pkg::CMD_ALL_CLEAR |=> s_reg.lock_err ##1 !s_reg.ready)
    else $error("erase of all fuses not refused");

  a_status_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    req && !wb_i.we && wb_i.adr == fuse_guard_pkg::ADDR_STATUS |=> !s_reg.lock_err && !s_reg.prog_err)
    else $error("status read did not clear errors");

  a_secure_decode: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    secure_state_enable_o == (s_reg.fuses[21] ^ s_reg.fuses[20])
      && secure_debug_enable_o == (!s_reg.fuses[21] && s_reg.fuses[20]))
    else $error("secure decode mismatch");

  a_boot_page_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    page_query_i == 16'h0000 && s_reg.fuses[19:17] != 3'h7 |=> page_denied_o)
    else $error("boot page zero not denied");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_o.ack ##1 !wb_o.ack)
    else $error("ack not a single cycle");

  a_busy_cmd_refused: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    cmd_wr && s_reg.busy |=> s_reg.prog_err && $stable(s_reg.pend))
    else $error("command during busy period not refused");

  a_bad_code_flags: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    cmd_wr && key == fuse_guard_pkg::CMD_KEY && !s_reg.busy && !valid |=> s_reg.prog_err && s_reg.ready)
    else $error("invalid command did not flag program error");

  a_lock_flagged: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    cmd_wr && key == fuse_guard_pkg::CMD_KEY && !s_reg.busy && valid && lock_fail
    |=> s_reg.lock_err && !s_reg.ready)
    else $error("protected fuse change did not flag lock error");

  a_secure_fuses_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    s_reg.busy && s_reg.cnt == 8'h01 && s_reg.sec_en
    |=> (s_reg.fuses & fuse_guard_pkg::SECURE_MSK) == ($past(s_reg.fuses) & fuse_guard_pkg::SECURE_MSK))
    else $error("secure fuse changed in secure mode");

  a_irq_on_done: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    s_reg.busy && s_reg.cnt == 8'h01 |=> s_reg.ready && irq_o == $past(s_reg.rdy_ie))
    else $error("completion did not raise ready or interrupt");

  a_irq_single: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");

  a_ready_idle: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    !s_reg.busy |-> s_reg.ready)
    else $error("ready low while idle");

  a_region_denied: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    !s_reg.fuses[page_query_i[fuse_guard_pkg::REGION_LSB +: 4]] |=> page_denied_o)
    else $error("page in locked region not denied");

  a_boot_none_free: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    s_reg.fuses[19:fuse_guard_pkg::BOOT_LSB] == 3'h7
      && s_reg.fuses[page_query_i[fuse_guard_pkg::REGION_LSB +: 4]]
    |=> !page_denied_o)
    else $error("unprotected page denied");

endmodule // fuse_bit_command_guard
